// file: logic/tpc_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpc_consts.svh"
module tpc_regs #(
  parameter int IND_DEPTH = 256
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register access
  input wire tpc_pkg::tpc_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // generator side
  input wire logic frame_start_i,
  input wire logic [15:0] pattern_enable_i,
  output tpc_pkg::tpc_ctrl_s ctrl_o,
  output logic [7:0] frame_dwell_count_o,
  output logic use_ext_pclk_o
);
  // register map as software sees it over the serial control bus:
  //   control - fixed pattern select in 7:4, reset value selects pattern 1
  //   config - scroll, invert, timing select, external clock, 18-bit mode
  //   index - picks the indirect byte that the value address reaches
  //   value - window onto the indirect store
  //   indirect byte 0 - frame dwell count, reset to one frame
  // every control the generator uses is copied to the live set at frame
  // start only, so software may write at any time without tearing a frame
  // limitation: writes have no response, so software cannot tell when a
  // setting went live other than by counting frames
  // reads answer one cycle after the strobe with rvalid_o; read data
  // then holds until the next read so a slow master can still pick it up
  // the clock source flag is forced to the external clock whenever
  // external timing is chosen, because the bit has no meaning there
  // scroll walks the patterns 1 to 14 that pattern_enable_i allows,
  // wrapping from the last enabled one back to the first
  // reserved config bits are dropped on write and read back as zero

  // bus-facing registers
  logic [7:0] ctrl_reg_ff, nxt_ctrl_reg;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] indirect_index_ff, nxt_indirect_index;

  // indirect store, byte 0 is the frame dwell count
  logic [7:0] ind_mem_ff [IND_DEPTH];

  // read answer
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;

  // frame-synchronous copies seen by the generator
  tpc_pkg::tpc_ctrl_s live_ff, nxt_live;

  // scroll state: current scroll pattern and frames spent on it
  logic [3:0] scroll_pat_ff, nxt_scroll_pat;
  logic [7:0] frames_ff, nxt_frames;
  logic [7:0] dwell_ff, nxt_dwell;
  logic ext_ff, nxt_ext;

  // address match; a function since every decode below uses it
  function automatic logic hit(input tpc_pkg::tpc_req_s r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // next enabled pattern after the current one, wrapping over the usable range
  // trade-off: a fixed 14-step loop is larger than a priority encoder
  // but keeps the wrap order plain; no enabled pattern keeps the current one
  // patterns 0 and 15 are never chosen, they are reserved
  function automatic logic [3:0] next_pat(input logic [3:0] cur, input logic [15:0] en);
    logic [3:0] p;
    logic found;
    p = cur;
    found = 1'b0;
    for (int i = 0; i < 14; i++) begin
      p = (p >= `TPC_PAT_LAST || p < `TPC_PAT_FIRST) ? `TPC_PAT_FIRST : 4'(p + 4'h1);
      if (!found && en[p]) begin
        found = 1'b1;
        next_pat = p;
      end
    end
    if (!found) begin
      next_pat = cur;
    end
  endfunction

  // register writes and read data
  // unmapped addresses read zero and ignore writes
  // a value read uses the index as it stands before any write in the
  // same cycle; a master never issues both strobes at once
  always_comb begin
    nxt_ctrl_reg = ctrl_reg_ff;
    nxt_cfg = cfg_ff;
    nxt_indirect_index = indirect_index_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = req_i.rd;
    if (req_i.wr) begin
      if (hit(req_i, `TPC_ADDR_CTRL)) begin
        nxt_ctrl_reg = req_i.wdata;
      end
      if (hit(req_i, `TPC_ADDR_CONFIG)) begin
        nxt_cfg = req_i.wdata & `TPC_CFG_MASK; // reserved bits read zero
      end
      if (hit(req_i, `TPC_ADDR_INDEX)) begin
        nxt_indirect_index = req_i.wdata;
      end
    end
    // read data follows the decoded address
    if (req_i.rd) begin
      if (hit(req_i, `TPC_ADDR_CTRL)) begin
        nxt_rdata = ctrl_reg_ff;
      end else if (hit(req_i, `TPC_ADDR_CONFIG)) begin
        nxt_rdata = cfg_ff;
      end else if (hit(req_i, `TPC_ADDR_INDEX)) begin
        nxt_rdata = indirect_index_ff;
      end else if (hit(req_i, `TPC_ADDR_VALUE)) begin
        nxt_rdata = ind_mem_ff[indirect_index_ff];
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  // bus registers, asynchronous reset to their defaults
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg_ff <= `TPC_CTRL_RESET;
      cfg_ff <= `TPC_CONFIG_RESET;
      indirect_index_ff <= `TPC_INDEX_RESET;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      ctrl_reg_ff <= nxt_ctrl_reg;
      cfg_ff <= nxt_cfg;
      indirect_index_ff <= nxt_indirect_index;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // indirect storage; the index must already be loaded by software
  // hazard: a value access before the index is loaded reaches whatever
  // byte the stale index points at; nothing here can detect that
  // the store has no byte enables, each write replaces a whole byte
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < IND_DEPTH; i++) begin
        ind_mem_ff[i] <= (i == 0) ? `TPC_DWELL_RESET : 8'h00;
      end
    end else if (req_i.wr && hit(req_i, `TPC_ADDR_VALUE)) begin
      ind_mem_ff[indirect_index_ff] <= req_i.wdata;
    end
  end

  // live settings: sampled only at frame start so a frame never mixes settings
  always_comb begin
    nxt_live = live_ff;
    nxt_scroll_pat = scroll_pat_ff;
    nxt_frames = frames_ff;
    nxt_dwell = dwell_ff;
    nxt_ext = ext_ff;
    if (frame_start_i) begin
      // copy the config bits as they stand at this frame start
      nxt_live.timing_source_select = cfg_ff[`TPC_BIT_TSEL];
      nxt_live.ext_clk_sel = cfg_ff[`TPC_BIT_EXTCLK];
      nxt_live.invert = cfg_ff[`TPC_BIT_INVERT];
      nxt_live.scroll = cfg_ff[`TPC_BIT_SCROLL];
      nxt_live.color_18b = cfg_ff[`TPC_BIT_18B];
      nxt_dwell = ind_mem_ff[`TPC_IDX_DWELL];
      // external timing forces the external pixel clock; bit 3 is moot there
      nxt_ext = !cfg_ff[`TPC_BIT_TSEL] || cfg_ff[`TPC_BIT_EXTCLK];
      // scroll bookkeeping: the first scrolling frame starts from the last
      // fixed pattern; a dwell of zero behaves like a dwell of one frame
      // scroll off clears the frame counter so a later scroll starts fresh
      if (cfg_ff[`TPC_BIT_SCROLL]) begin
        // fixed select ignored while scrolling
        if (!live_ff.scroll) begin
          nxt_scroll_pat = live_ff.pattern;
          nxt_frames = 8'h00;
        end else if (8'(frames_ff + 8'h01) >= dwell_ff) begin
          nxt_scroll_pat = next_pat(scroll_pat_ff, pattern_enable_i);
          nxt_frames = 8'h00;
        end else begin
          nxt_frames = 8'(frames_ff + 8'h01);
        end
        nxt_live.pattern = nxt_scroll_pat;
      end else begin
        nxt_live.pattern = ctrl_reg_ff[7:4];
        nxt_frames = 8'h00;
      end
    end
  end

  // live copies; reset leaves external timing and its clock in force
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      live_ff <= '0;
      scroll_pat_ff <= `TPC_PAT_FIRST;
      frames_ff <= 8'h00;
      dwell_ff <= `TPC_DWELL_RESET;
      ext_ff <= 1'b1;
    end else begin
      live_ff <= nxt_live;
      scroll_pat_ff <= nxt_scroll_pat;
      frames_ff <= nxt_frames;
      dwell_ff <= nxt_dwell;
      ext_ff <= nxt_ext;
    end
  end

  // outputs straight from their flip-flops
  assign rdata_o = rdata_ff;
  assign rvalid_o = rvalid_ff;
  assign ctrl_o = live_ff;
  assign frame_dwell_count_o = dwell_ff;
  assign use_ext_pclk_o = ext_ff;
endmodule // tpc_regs
`default_nettype wire

// file: logic/tpc_consts.svh
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
`define TPC_ADDR_CTRL 8'h64
`define TPC_ADDR_CONFIG 8'h65
`define TPC_ADDR_INDEX 8'h66
`define TPC_ADDR_VALUE 8'h67
`define TPC_CTRL_RESET 8'h10
`define TPC_CONFIG_RESET 8'h00
`define TPC_INDEX_RESET 8'h00
`define TPC_BIT_SCROLL 0
`define TPC_BIT_INVERT 1
`define TPC_BIT_TSEL 2
`define TPC_BIT_EXTCLK 3
`define TPC_BIT_18B 4
`define TPC_CFG_MASK 8'h1f
`define TPC_IDX_DWELL 8'h00
`define TPC_DWELL_RESET 8'h01
`define TPC_PAT_FIRST 4'h1
`define TPC_PAT_LAST 4'he
`endif

// file: logic/tpc_pkg.sv
package tpc_pkg;
  // live controls as the generator sees them
  typedef struct packed {
    logic timing_source_select;
    logic ext_clk_sel;
    logic invert;
    logic scroll;
    logic color_18b;
    logic [3:0] pattern;
  } tpc_ctrl_s;
  // serial control bus register access, one cycle strobe
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpc_req_s;
endpackage

// file: verif/tpc_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_regs_monitor (
  // watched ports
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire tpc_pkg::tpc_req_s req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic frame_start_i,
  input wire logic [15:0] pattern_enable_i,
  input wire tpc_pkg::tpc_ctrl_s ctrl_o,
  input wire logic [7:0] frame_dwell_count_o,
  input wire logic use_ext_pclk_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a read is one strobe, answered one cycle later
  sequence rd_s; req_i.rd; endsequence
  sequence idle_s; !req_i.rd; endsequence
  read_answer_a: assert property (rd_s |=> rvalid_o) else $error("no rvalid");
  stray_valid_a: assert property (idle_s |=> !rvalid_o) else $error("stray rvalid");
  rdata_hold_a: assert property (idle_s |=> $stable(rdata_o)) else $error("rdata moved");
  // mid-frame changes would split a frame across two settings
  ctrl_hold_a: assert property (!frame_start_i |=> $stable(ctrl_o)) else $error("ctrl moved");
  dwell_hold_a: assert property (!frame_start_i |=> $stable(frame_dwell_count_o)) else $error("dwell");
  pclk_hold_a: assert property (!frame_start_i |=> $stable(use_ext_pclk_o)) else $error("pclk");
  pclk_sel_a: assert property (use_ext_pclk_o == (!ctrl_o.timing_source_select || ctrl_o.ext_clk_sel))
    else $error("pclk select");
  scroll_en_a: assert property ($past(ctrl_o.scroll) && ctrl_o.scroll && $changed(ctrl_o.pattern)
    |-> pattern_enable_i[ctrl_o.pattern]) else $error("scroll step");
endmodule // tpc_regs_monitor
bind tpc_regs tpc_regs_monitor mon (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .frame_start_i(frame_start_i), .pattern_enable_i(pattern_enable_i), .ctrl_o(ctrl_o),
  .frame_dwell_count_o(frame_dwell_count_o), .use_ext_pclk_o(use_ext_pclk_o));
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpc_consts.svh"
module testbench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic frame_start_i = 1'b0;
  tpc_pkg::tpc_req_s req_i = '0;
  logic [7:0] rdata_o, frame_dwell_count_o, r;
  logic rvalid_o, use_ext_pclk_o;
  tpc_pkg::tpc_ctrl_s ctrl_o;
  logic [3:0] p;
  logic [15:0] pattern_enable_i = 16'h0028;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  tpc_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .frame_start_i(frame_start_i), .pattern_enable_i(pattern_enable_i), .ctrl_o(ctrl_o),
    .frame_dwell_count_o(frame_dwell_count_o), .use_ext_pclk_o(use_ext_pclk_o));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // expected pclk flag and live controls
  function automatic logic [9:0] exp(input logic [7:0] c, input logic [3:0] q);
    return {!c[2] || c[3], c[2], c[3], c[1], c[0], c[4], q};
  endfunction
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // each access idles a cycle so the strobe is never driven twice at once
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    req_i <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_i);
    req_i <= '0;
    if (!w) chk({rvalid_o, 1'b0, rdata_o}, {2'b10, d});
    @(negedge clk_i);
  endtask
  task automatic fs();
    frame_start_i <= 1'b1;
    @(negedge clk_i);
    frame_start_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    n = $urandom(2269);
    repeat (10) @(negedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk({use_ext_pclk_o, ctrl_o}, 10'h200);
    acc(0, `TPC_ADDR_CTRL, `TPC_CTRL_RESET);
    acc(0, `TPC_ADDR_INDEX, `TPC_INDEX_RESET);
    acc(0, `TPC_ADDR_VALUE, `TPC_DWELL_RESET);
    acc(1, 8'h80, 8'h5a);
    acc(0, 8'h80, 8'h00);
    // random settings, scroll off: fixed pattern holds over frames
    repeat (6) begin
      r = 8'($urandom) & 8'hfe;
      p = 4'($urandom_range(14, 1));
      acc(1, `TPC_ADDR_CTRL, {p, 4'h0});
      acc(1, `TPC_ADDR_CONFIG, r);
      acc(0, `TPC_ADDR_CONFIG, r & `TPC_CFG_MASK);
      repeat (2) fs();
      chk({use_ext_pclk_o, ctrl_o}, exp(r, p));
    end
    repeat (4) begin
      r = 8'($urandom_range(255, 1));
      p = 4'($urandom);
      acc(1, `TPC_ADDR_INDEX, r);
      acc(1, `TPC_ADDR_VALUE, {p, ~p});
      acc(0, `TPC_ADDR_INDEX, r);
      acc(0, `TPC_ADDR_VALUE, {p, ~p});
    end
    // scroll over patterns 3 and 5 with a dwell of two frames
    acc(1, `TPC_ADDR_INDEX, `TPC_IDX_DWELL);
    acc(1, `TPC_ADDR_VALUE, 8'h02);
    acc(1, `TPC_ADDR_CTRL, 8'h10);
    acc(1, `TPC_ADDR_CONFIG, 8'h01);
    fs();
    chk({2'b00, frame_dwell_count_o}, 10'h002);
    acc(1, `TPC_ADDR_CTRL, 8'h70);
    n = 0;
    while (ctrl_o.pattern !== 4'h3 && n < 8) begin
      fs();
      n++;
    end
    if (n == 8) begin
      miscompares++;
      $display("MISMATCH %0t scroll never reached pattern 3", $time);
    end else begin
      for (int k = 0; k < 4; k++) begin
        fs();
        chk({use_ext_pclk_o, ctrl_o}, exp(8'h01, (k == 1 || k == 2) ? 4'h5 : 4'h3));
      end
      // nothing enabled: scrolling keeps the pattern it has
      pattern_enable_i <= 16'h0000;
      repeat (3) fs();
      chk({use_ext_pclk_o, ctrl_o}, exp(8'h01, 4'h3));
    end
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
